// [rtl/sit_pkg.sv]
/*
 Package for the serial IRQ trigger select and level status block.
 Assumes a register window with byte addresses and 16-bit register data.
*/
package sit_pkg;
   localparam int          SIT_LINES        = 16;
   localparam int          SIT_ADDR_W       = 8;
   localparam int          SIT_DATA_W       = 16;
   localparam logic [7:0]  SIT_OFS_TRIGGER  = 8'h4a;
   localparam logic [7:0]  SIT_OFS_STATUS   = 8'h4c;
   localparam logic [15:0] SIT_TRIGGER_RST  = 16'h0000;
   localparam logic [15:0] SIT_STATUS_RST   = 16'h0000;
   localparam logic        SIT_MODE_EDGE    = 1'b0;
   localparam logic        SIT_MODE_LEVEL   = 1'b1;

   typedef struct packed {
      logic                  wr;
      logic                  rd;
      logic [SIT_ADDR_W-1:0] addr;
      logic [SIT_DATA_W-1:0] wdata;
   } sit_req_type;
endpackage

// [rtl/sit_serial_irq_trigger_status.sv]
/*
 Trigger selection and latched level status for sixteen serial IRQ lines.
 Assumes decoded line states arrive as one word per sample strobe, and a
 simple register port with one-cycle read and write strobes.
*/
// Notes on behaviour
// - Each line has a trigger-select bit at its own position, 0 for edge (default) and 1 for level.
// - A level line sampled asserted sets and holds its status flag.
// - Writing 1 to a set status flag clears it unless the line is in level handling and sampled asserted in that cycle, so a later assertion shows again.
// - A line in edge handling never sets its status flag.
// - Each status flag reads 1 while latched and 0 otherwise, at the line's bit position.
// - All trigger-select bits and status flags clear on any of the three resets.
// - The trigger-select register decodes at offset 4Ah and resets to zero.
`timescale 1ns/1ps
`default_nettype none
module sit_serial_irq_trigger_status
   import sit_pkg::*;
#(
   parameter int LINES = SIT_LINES
)
(
   input  wire logic                  CORE_CLK,
   input  wire logic                  ARST_N,
   input  wire logic                  PCIE_FUNDAMENTAL_RESET_N,
   input  wire logic                  GLOBAL_RESET_INPUT_N,
   input  wire sit_req_type           REG_REQ,
   output logic      [SIT_DATA_W-1:0] REG_RDATA,
   input  wire logic                  IRQ_SAMPLE_VALID,
   input  wire logic [LINES-1:0]      IRQ_LINES,
   output logic      [LINES-1:0]      EDGE_IRQ_PULSE,
   output logic      [LINES-1:0]      TRIGGER_SELECT,
   output logic      [LINES-1:0]      LEVEL_STATUS
);
   // Decode strobes
   logic                  soft_reset;
   logic                  hit_trigger;
   logic                  hit_status;
   logic                  wr_trigger;
   logic                  wr_status;
   logic                  rd_trigger;
   logic                  rd_status;
   logic [LINES-1:0]      wdata_lines;

   // Per-line working values
   logic [LINES-1:0]      prev_lines;
   logic [LINES-1:0]      level_mode;
   logic [LINES-1:0]      sampled_high;
   logic [LINES-1:0]      level_hit;
   logic [LINES-1:0]      rearm_mask;
   logic [LINES-1:0]      edge_rise;

   // Next values
   logic [LINES-1:0]      next_trigger;
   logic [LINES-1:0]      next_status;
   logic [LINES-1:0]      next_prev;
   logic [LINES-1:0]      next_pulse;
   logic [SIT_DATA_W-1:0] trigger_word;
   logic [SIT_DATA_W-1:0] status_word;
   logic [SIT_DATA_W-1:0] next_rdata;

   // Either synchronous reset input
   assign soft_reset = !PCIE_FUNDAMENTAL_RESET_N || !GLOBAL_RESET_INPUT_N;

   // Register window decode
   assign hit_trigger = (REG_REQ.addr == SIT_OFS_TRIGGER);
   assign hit_status  = (REG_REQ.addr == SIT_OFS_STATUS);
   assign wr_trigger  = REG_REQ.wr && hit_trigger;
   assign wr_status   = REG_REQ.wr && hit_status;
   assign rd_trigger  = REG_REQ.rd && hit_trigger;
   assign rd_status   = REG_REQ.rd && hit_status;
   assign wdata_lines = REG_REQ.wdata[LINES-1:0];

   // Lines in level handling
   always_comb begin
      level_mode = '0;
      for (int i = 0; i < LINES; i++) begin
         level_mode[i] = (TRIGGER_SELECT[i] == SIT_MODE_LEVEL);
      end
   end

   // Lines sampled asserted
   always_comb begin
      sampled_high = '0;
      for (int i = 0; i < LINES; i++) begin
         sampled_high[i] = IRQ_SAMPLE_VALID && IRQ_LINES[i];
      end
   end

   // Level lines that latch now
   always_comb begin
      level_hit = '0;
      for (int i = 0; i < LINES; i++) begin
         level_hit[i] = sampled_high[i] && level_mode[i];
      end
   end

   // Status bits written with one
   always_comb begin
      rearm_mask = '0;
      for (int i = 0; i < LINES; i++) begin
         rearm_mask[i] = wr_status && wdata_lines[i];
      end
   end

   // New assertions of edge lines
   always_comb begin
      edge_rise = '0;
      for (int i = 0; i < LINES; i++) begin
         edge_rise[i] = sampled_high[i] && !prev_lines[i] && !level_mode[i];
      end
   end

   // Next trigger select
   always_comb begin
      next_trigger = TRIGGER_SELECT;
      if (soft_reset) begin
         next_trigger = SIT_TRIGGER_RST[LINES-1:0];
      end else if (wr_trigger) begin
         next_trigger = wdata_lines;
      end
   end

   // Next level status, set wins over re-arm
   always_comb begin
      next_status = LEVEL_STATUS;
      if (soft_reset) begin
         next_status = SIT_STATUS_RST[LINES-1:0];
      end else begin
         for (int i = 0; i < LINES; i++) begin
            if (level_hit[i]) begin
               next_status[i] = 1'b1;
            end else if (rearm_mask[i]) begin
               next_status[i] = 1'b0;
            end
         end
      end
   end

   // Next edge history
   always_comb begin
      next_prev = prev_lines;
      if (soft_reset) begin
         next_prev = '0;
      end else if (IRQ_SAMPLE_VALID) begin
         next_prev = IRQ_LINES;
      end
   end

   // Next edge pulse
   always_comb begin
      next_pulse = '0;
      if (!soft_reset && IRQ_SAMPLE_VALID) begin
         next_pulse = edge_rise;
      end
   end

   // Trigger select widened to the data bus
   always_comb begin
      trigger_word            = '0;
      trigger_word[LINES-1:0] = TRIGGER_SELECT;
   end

   // Level status widened to the data bus
   always_comb begin
      status_word            = '0;
      status_word[LINES-1:0] = LEVEL_STATUS;
   end

   // Next read data, zero when idle or unmapped
   always_comb begin
      next_rdata = '0;
      if (rd_trigger) begin
         next_rdata = trigger_word;
      end else if (rd_status) begin
         next_rdata = status_word;
      end
   end

   // Trigger select register
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         TRIGGER_SELECT <= SIT_TRIGGER_RST[LINES-1:0];
      end else begin
         TRIGGER_SELECT <= next_trigger;
      end
   end

   // Level status register
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         LEVEL_STATUS <= SIT_STATUS_RST[LINES-1:0];
      end else begin
         LEVEL_STATUS <= next_status;
      end
   end

   // Edge history
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prev_lines <= '0;
      end else begin
         prev_lines <= next_prev;
      end
   end

   // Edge pulse
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         EDGE_IRQ_PULSE <= '0;
      end else begin
         EDGE_IRQ_PULSE <= next_pulse;
      end
   end

   // Read data
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         REG_RDATA <= '0;
      end else begin
         REG_RDATA <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// [bench/sit_irq_src.sv]
/* Far-side IRQ sample source. Assumes the bench clock; drives on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module sit_irq_src (
   input  wire logic   clk,
   output logic        vld,
   output logic [15:0] lines
);
   initial begin vld = 0; lines = 0; end
   task automatic send(input logic [15:0] v); @(negedge clk); vld = 1; lines = v; @(negedge clk); vld = 0; lines = ~v; endtask
endmodule
`default_nettype wire

// [bench/sit_props.sv]
/* Checker on the top ports. Assumes bind into the design top. */
`timescale 1ns/1ps
`default_nettype none
module sit_props
   import sit_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        ARST_N,
   input  wire logic        PCIE_FUNDAMENTAL_RESET_N,
   input  wire logic        GLOBAL_RESET_INPUT_N,
   input  wire logic        IRQ_SAMPLE_VALID,
   input  wire sit_req_type REG_REQ,
   input  wire logic [15:0] REG_RDATA,
   input  wire logic [15:0] IRQ_LINES,
   input  wire logic [15:0] EDGE_IRQ_PULSE,
   input  wire logic [15:0] TRIGGER_SELECT,
   input  wire logic [15:0] LEVEL_STATUS
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);
   wire s = PCIE_FUNDAMENTAL_RESET_N && GLOBAL_RESET_INPUT_N;
   wire [15:0] lv = IRQ_LINES & TRIGGER_SELECT;
   trig_write_a: assert property (s && REG_REQ.wr && REG_REQ.addr == 8'h4a |=> TRIGGER_SELECT == $past(REG_REQ.wdata)) else $error("trigger write");
   trig_read_a: assert property (s && REG_REQ.rd && REG_REQ.addr == 8'h4a |=> REG_RDATA == $past(TRIGGER_SELECT)) else $error("trigger read");
   level_set_a: assert property (s && IRQ_SAMPLE_VALID |=> (LEVEL_STATUS & $past(lv)) == $past(lv)) else $error("level set");
   status_hold_a: assert property (s && !REG_REQ.wr |=> (LEVEL_STATUS & $past(LEVEL_STATUS)) == $past(LEVEL_STATUS)) else $error("hold");
   w1c_clear_a: assert property (s && REG_REQ.wr && REG_REQ.addr == 8'h4c && !IRQ_SAMPLE_VALID |=> (LEVEL_STATUS & $past(REG_REQ.wdata)) == 0) else $error("clear");
   edge_nostat_a: assert property ((LEVEL_STATUS & ~$past(LEVEL_STATUS) & ~$past(TRIGGER_SELECT)) == 0) else $error("edge status");
   sync_reset_a: assert property (!s |=> TRIGGER_SELECT == 0 && LEVEL_STATUS == 0) else $error("sync reset");
   edge_pulse_a: assert property (EDGE_IRQ_PULSE != 0 |-> $past(IRQ_SAMPLE_VALID) && (EDGE_IRQ_PULSE & $past(TRIGGER_SELECT)) == 0) else $error("pulse");
endmodule
bind sit_serial_irq_trigger_status sit_props sit_props_i (.*);
`default_nettype wire

// [bench/tb.sv]
/* Self-checking bench. Assumes sit_irq_src as the far side. */
`timescale 1ns/1ps
`default_nettype none
module tb import sit_pkg::*; ;
   logic clk = 0, rst_n = 0, pr_n = 1, gr_n = 1, v;
   sit_req_type rq = '0;
   logic [15:0] rd, ep, ts, ls, ln;
   logic [15:0] rows [4][4] = '{'{16'h0001, 16'h0001, 16'h0001, 16'h0000}, '{16'h8000, 16'hffff, 16'h8000, 16'h7fff},
                               '{16'h0000, 16'ha5a5, 16'h0000, 16'ha5a5}, '{16'hffff, 16'h5a5a, 16'h5a5a, 16'h0000}};
   int num_errors = 0, checks_done = 0, cyc = 0;
   always #4 clk = ~clk;
   sit_serial_irq_trigger_status sit_serial_irq_trigger_status_i (.CORE_CLK(clk), .ARST_N(rst_n), .PCIE_FUNDAMENTAL_RESET_N(pr_n),
      .GLOBAL_RESET_INPUT_N(gr_n), .REG_REQ(rq), .REG_RDATA(rd), .IRQ_SAMPLE_VALID(v), .IRQ_LINES(ln),
      .EDGE_IRQ_PULSE(ep), .TRIGGER_SELECT(ts), .LEVEL_STATUS(ls));
   sit_irq_src sit_irq_src_i (.clk(clk), .vld(v), .lines(ln));
   task automatic cmp(input logic [15:0] g, e); checks_done++; if (g !== e) begin num_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(negedge clk); rq = '{w, !w, a, d}; @(negedge clk); if (!w) cmp(rd, d); rq = '0;
      if (!w) begin
         @(negedge clk);
         cmp(rd, 16'h0000);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) if (++cyc > 2000) begin num_errors++; print_verdict; end
   initial begin
      repeat (4) @(negedge clk); rst_n = 1; cmp(ts, 16'h0000); cmp(ls, 16'h0000);
      foreach (rows[i]) begin
         acc(1, 8'h4c, 16'hffff); acc(1, 8'h4a, rows[i][0]); cmp(ts, rows[i][0]);
         sit_irq_src_i.send(16'h0000); sit_irq_src_i.send(rows[i][1]);
         cmp(ls, rows[i][2]);
         cmp(ep, rows[i][3]);
         $display("row %0d done", i);
      end
      acc(1, 8'h4c, 16'h0002); sit_irq_src_i.send(16'h0000); cmp(ls, 16'h5a58);
      acc(0, 8'h4c, 16'h5a58); acc(0, 8'h4a, 16'hffff); acc(0, 8'h4e, 16'h0000);
      acc(1, 8'h4e, 16'h0000); cmp(ts, 16'hffff);
      acc(1, 8'h4c, 16'h0008);
      cmp(ls, 16'h5a50);
      sit_irq_src_i.send(16'h0008);
      cmp(ls, 16'h5a58);
      acc(1, 8'h4a, 16'h0000);
      sit_irq_src_i.send(16'h0000);
      sit_irq_src_i.send(16'h0010);
      cmp(ep, 16'h0010);
      sit_irq_src_i.send(16'h0010);
      cmp(ep, 16'h0000);
      cmp(ls, 16'h5a58);
      $display("rearm and edge cases done");
      for (int k = 0; k < 2; k++) begin
         acc(1, 8'h4a, 16'h00ff); {pr_n, gr_n} = k ? 2'b10 : 2'b01; @(negedge clk); {pr_n, gr_n} = 2'b11;
         cmp(ts, 16'h0000); cmp(ls, 16'h0000);
      end
      acc(1, 8'h4a, 16'h00ff);
      sit_irq_src_i.send(16'h0001);
      cmp(ls, 16'h0001);
      @(negedge clk);
      rst_n = 0;
      @(negedge clk);
      rst_n = 1;
      cmp(ts, 16'h0000);
      cmp(ls, 16'h0000);
      sit_irq_src_i.send(16'h0001);
      cmp(ep, 16'h0001);
      $display("special cases done");
      print_verdict;
   end
endmodule
`default_nettype wire
